// file: common/cdt_pkg.sv
package cdt_pkg;

    localparam int APB_AW = 5;

    // register byte offsets
    localparam logic [4:0] OFF_CTRL_LO   = 5'h00;
    localparam logic [4:0] OFF_CTRL_HI   = 5'h04;
    localparam logic [4:0] OFF_COUNT_LO  = 5'h08;
    localparam logic [4:0] OFF_COUNT_HI  = 5'h0C;
    localparam logic [4:0] OFF_PERIOD_LO = 5'h10;
    localparam logic [4:0] OFF_PERIOD_HI = 5'h14;
    localparam logic [4:0] OFF_IRQ_STAT  = 5'h18;
    localparam logic [4:0] OFF_IRQ_MASK  = 5'h1C;

    // control field positions
    localparam int BIT_ON        = 15;
    localparam int BIT_HALT_IDLE = 13;
    localparam int BIT_GATE      = 6;
    localparam int BIT_PS_MSB    = 5;
    localparam int BIT_PS_LSB    = 4;
    localparam int BIT_JOIN      = 3;
    localparam int BIT_CS        = 1;

    // implemented bits of each control register
    localparam logic [15:0] MASK_CTRL_LO = 16'hA07A;
    localparam logic [15:0] MASK_CTRL_HI = 16'hA072;

    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic [15:0] RST_PERIOD = 16'hFFFF;

    // interrupt status / mask layout
    localparam int IRQ_W  = 2;
    localparam int IRQ_LO = 0;
    localparam int IRQ_HI = 1;
    localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

    // prescaler terminal counts: ratio minus one
    localparam logic [7:0] PS_LIM_1   = 8'h00;
    localparam logic [7:0] PS_LIM_8   = 8'h07;
    localparam logic [7:0] PS_LIM_64  = 8'h3F;
    localparam logic [7:0] PS_LIM_256 = 8'hFF;

    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        logic [7:0] lim;
        unique case (sel)
            2'h0: lim = PS_LIM_1;
            2'h1: lim = PS_LIM_8;
            2'h2: lim = PS_LIM_64;
            2'h3: lim = PS_LIM_256;
        endcase
        return lim;
    endfunction

endpackage

// file: verilog/cdt_sync.sv
module cdt_sync
    import cdt_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    if (W < 1) begin : g_bad_width
        $error("cdt_sync width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cdt_sync_state_t;

    cdt_sync_state_t st_q;
    cdt_sync_state_t st_d;

    // s1 may be metastable: only s2 reads it
    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sync_two_stage: assert property (
        $past(presetn, 2) |-> dout == $past(din, 2))
        else $error("synchroniser delay is not two cycles");

endmodule // cdt_sync

// file: verilog/cdt_prescaler.sv
module cdt_prescaler
    import cdt_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] prescale_select,
    output logic            tick_out
);

    if (CNT_W < 8) begin : g_bad_width
        $error("prescaler counter cannot reach 1:256");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             out;
    } cdt_ps_state_t;

    cdt_ps_state_t st_q;
    cdt_ps_state_t st_d;

    always_comb begin
        st_d     = st_q;
        st_d.out = 1'b0;
        if (clear) begin
            st_d.cnt = '0;
        end else if (tick_in) begin
            if (st_q.cnt >= CNT_W'(ps_limit(prescale_select))) begin
                st_d.cnt = '0;
                st_d.out = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_out = st_q.out;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || clear);

    a_ratio_eight_gap: assert property (
        (prescale_select == 2'h1 && tick_out) |=> (!tick_out)[*7])
        else $error("1:8 prescale pulsed too early");

    a_ratio_one_pass: assert property (
        (prescale_select == 2'h0 && tick_in) |=> tick_out)
        else $error("1:1 prescale dropped a tick");

endmodule // cdt_prescaler

// file: verilog/cdt_timer_pair.sv
module cdt_timer_pair
    import cdt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_count_input_lo,
    input  wire logic              external_count_input_hi,
    input  wire logic              cpu_idle,
    output logic                   irq
);

    typedef struct packed {
        logic [15:0]      ctrl_lo;
        logic [15:0]      ctrl_hi;
        logic [15:0]      cnt_lo;
        logic [15:0]      cnt_hi;
        logic [15:0]      per_lo;
        logic [15:0]      per_hi;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic             ext_lo_prev;
        logic             ext_hi_prev;
        logic             ps_lo_dly;
        logic             pready;
        logic             pslverr;
        logic             irq;
        logic [31:0]      prdata;
    } cdt_state_t;

    cdt_state_t st_q;
    cdt_state_t st_d;

    logic       apb_acc;
    logic       apb_wr;
    logic       wr_ctrl_lo;
    logic       wr_ctrl_hi;
    logic       wr_cnt_lo;
    logic       wr_cnt_hi;
    logic       ext_lo;
    logic       ext_hi;
    logic       join_wide_mode;
    logic       lo_on;
    logic       hi_on;
    logic       lo_run;
    logic       hi_run;
    logic       lo_gated;
    logic       hi_gated;
    logic       lo_src;
    logic       hi_src;
    logic       lo_ps_out;
    logic       hi_ps_out;
    logic       tick_lo;
    logic       tick_hi;
    logic       gate_fall_lo;
    logic       gate_fall_hi;
    logic       lo_wrap;
    logic       hi_wrap;
    logic       wide_wrap;

    // access completes one cycle after penable rises
    assign apb_acc    = psel && penable && !st_q.pready;
    assign apb_wr     = apb_acc && pwrite;
    assign wr_ctrl_lo = apb_wr && paddr == OFF_CTRL_LO;
    assign wr_ctrl_hi = apb_wr && paddr == OFF_CTRL_HI;
    assign wr_cnt_lo  = apb_wr && paddr == OFF_COUNT_LO;
    assign wr_cnt_hi  = apb_wr && paddr == OFF_COUNT_HI;

    cdt_sync #(
        .W(2)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({external_count_input_hi, external_count_input_lo}),
        .dout    ({ext_hi, ext_lo})
    );

    assign join_wide_mode = st_q.ctrl_lo[BIT_JOIN];

    // low on bit drives both words when joined
    assign lo_on = st_q.ctrl_lo[BIT_ON];
    assign hi_on = st_q.ctrl_hi[BIT_ON] && !join_wide_mode;

    // idle halt; joined also honours the high halt bit
    assign lo_run = lo_on && !(cpu_idle && (st_q.ctrl_lo[BIT_HALT_IDLE]
                    || (join_wide_mode && st_q.ctrl_hi[BIT_HALT_IDLE])));
    assign hi_run = hi_on && !(cpu_idle && st_q.ctrl_hi[BIT_HALT_IDLE]);

    assign lo_gated = st_q.ctrl_lo[BIT_GATE] && !st_q.ctrl_lo[BIT_CS];
    assign hi_gated = st_q.ctrl_hi[BIT_GATE] && !st_q.ctrl_hi[BIT_CS];

    // count source select; gate qualifies internal ticks
    assign lo_src = st_q.ctrl_lo[BIT_CS] ? (ext_lo && !st_q.ext_lo_prev)
                  : (lo_gated ? ext_lo : 1'b1);
    assign hi_src = st_q.ctrl_hi[BIT_CS] ? (ext_hi && !st_q.ext_hi_prev)
                  : (hi_gated ? ext_hi : 1'b1);

    // a control write restarts the prescaler so a new ratio starts clean
    cdt_prescaler #(
        .CNT_W(8)
    ) u_ps_lo (
        .pclk            (pclk),
        .presetn         (presetn),
        .clear           (!lo_run || wr_ctrl_lo),
        .tick_in         (lo_run && lo_src),
        .prescale_select (st_q.ctrl_lo[BIT_PS_MSB:BIT_PS_LSB]),
        .tick_out        (lo_ps_out)
    );

    cdt_prescaler #(
        .CNT_W(8)
    ) u_ps_hi (
        .pclk            (pclk),
        .presetn         (presetn),
        .clear           (!hi_run || wr_ctrl_hi),
        .tick_in         (hi_run && hi_src),
        .prescale_select (st_q.ctrl_hi[BIT_PS_MSB:BIT_PS_LSB]),
        .tick_out        (hi_ps_out)
    );

    // low timer retimes after its prescaler, one cycle more latency
    assign tick_lo = st_q.ps_lo_dly && lo_run;
    assign tick_hi = hi_ps_out && hi_run;

    assign gate_fall_lo = lo_run && lo_gated && st_q.ext_lo_prev && !ext_lo;
    assign gate_fall_hi = hi_run && hi_gated && st_q.ext_hi_prev && !ext_hi;

    assign lo_wrap   = st_q.cnt_lo == st_q.per_lo;
    assign hi_wrap   = st_q.cnt_hi == st_q.per_hi;
    assign wide_wrap = {st_q.cnt_hi, st_q.cnt_lo} == {st_q.per_hi, st_q.per_lo};

    always_comb begin
        logic [IRQ_W-1:0] set;
        logic [IRQ_W-1:0] clr;
        set               = '0;
        clr               = '0;
        st_d              = st_q;
        st_d.ext_lo_prev  = ext_lo;
        st_d.ext_hi_prev  = ext_hi;
        st_d.ps_lo_dly    = lo_ps_out;

        if (join_wide_mode) begin
            // high word is upper half of one count
            if (tick_lo) begin
                if (wide_wrap) begin
                    {st_d.cnt_hi, st_d.cnt_lo} = 32'h0000_0000;
                    set[IRQ_HI] = 1'b1;
                end else begin
                    {st_d.cnt_hi, st_d.cnt_lo} = {st_q.cnt_hi, st_q.cnt_lo} + 32'h0000_0001;
                end
            end
            // joined events report on the high bit only
            if (gate_fall_lo) begin
                set[IRQ_HI] = 1'b1;
            end
        end else begin
            // each timer steps on its own
            if (tick_lo) begin
                if (lo_wrap) begin
                    st_d.cnt_lo = RST_COUNT;
                    set[IRQ_LO] = 1'b1;
                end else begin
                    st_d.cnt_lo = st_q.cnt_lo + 16'h0001;
                end
            end
            if (tick_hi) begin
                if (hi_wrap) begin
                    st_d.cnt_hi = RST_COUNT;
                    set[IRQ_HI] = 1'b1;
                end else begin
                    st_d.cnt_hi = st_q.cnt_hi + 16'h0001;
                end
            end
            if (gate_fall_lo) begin
                set[IRQ_LO] = 1'b1;
            end
            if (gate_fall_hi) begin
                set[IRQ_HI] = 1'b1;
            end
        end

        st_d.pready  = apb_acc;
        st_d.pslverr = 1'b0;
        if (!apb_acc) begin
            st_d.prdata = 32'h0000_0000;
        end
        if (apb_acc) begin
            st_d.prdata = 32'h0000_0000;
            case (paddr)
                OFF_CTRL_LO: begin
                    st_d.prdata[15:0] = st_q.ctrl_lo & MASK_CTRL_LO;
                    if (pwrite) begin
                        st_d.ctrl_lo = pwdata[15:0] & MASK_CTRL_LO;
                    end
                end
                OFF_CTRL_HI: begin
                    st_d.prdata[15:0] = st_q.ctrl_hi & MASK_CTRL_HI;
                    if (pwrite) begin
                        st_d.ctrl_hi = pwdata[15:0] & MASK_CTRL_HI;
                    end
                end
                // software count writes beat a same-cycle tick
                OFF_COUNT_LO: begin
                    st_d.prdata[15:0] = st_q.cnt_lo;
                    if (pwrite) begin
                        st_d.cnt_lo = pwdata[15:0];
                    end
                end
                OFF_COUNT_HI: begin
                    st_d.prdata[15:0] = st_q.cnt_hi;
                    if (pwrite) begin
                        st_d.cnt_hi = pwdata[15:0];
                    end
                end
                OFF_PERIOD_LO: begin
                    st_d.prdata[15:0] = st_q.per_lo;
                    if (pwrite) begin
                        st_d.per_lo = pwdata[15:0];
                    end
                end
                OFF_PERIOD_HI: begin
                    st_d.prdata[15:0] = st_q.per_hi;
                    if (pwrite) begin
                        st_d.per_hi = pwdata[15:0];
                    end
                end
                OFF_IRQ_STAT: begin
                    st_d.prdata[IRQ_W-1:0] = st_q.stat;
                    if (pwrite) begin
                        clr = pwdata[IRQ_W-1:0];
                    end
                end
                OFF_IRQ_MASK: begin
                    st_d.prdata[IRQ_W-1:0] = st_q.mask;
                    if (pwrite) begin
                        st_d.mask = pwdata[IRQ_W-1:0];
                    end
                end
                default: begin
                    st_d.pslverr = 1'b1;
                end
            endcase
        end

        // a new event wins over a write-one clear in the same cycle
        st_d.stat = (st_q.stat & ~clr) | set;
        st_d.irq  = |(st_d.stat & st_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q         <= '0;
            st_q.ctrl_lo <= RST_CTRL;
            st_q.ctrl_hi <= RST_CTRL;
            st_q.cnt_lo  <= RST_COUNT;
            st_q.cnt_hi  <= RST_COUNT;
            st_q.per_lo  <= RST_PERIOD;
            st_q.per_hi  <= RST_PERIOD;
            st_q.stat    <= RST_IRQ;
            st_q.mask    <= RST_IRQ;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata  = st_q.prdata;
    assign pready  = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign irq     = st_q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lo_wrap_cause;
        tick_lo && !join_wide_mode && lo_wrap && !apb_wr;
    endsequence

    sequence s_lo_wrapped;
        st_q.cnt_lo == 16'h0000 && st_q.stat[IRQ_LO];
    endsequence

    sequence s_carry_cause;
        join_wide_mode && tick_lo && st_q.cnt_lo == 16'hFFFF && !wide_wrap && !apb_wr;
    endsequence

    a_off_holds_count: assert property (
        (!join_wide_mode && !lo_on && !apb_wr) |=> $stable(st_q.cnt_lo))
        else $error("stopped low timer changed its count");

    a_joined_off_holds: assert property (
        (join_wide_mode && !lo_on && !apb_wr) |=> $stable({st_q.cnt_hi, st_q.cnt_lo}))
        else $error("stopped joined counter changed");

    a_idle_halt_holds: assert property (
        (cpu_idle && st_q.ctrl_lo[BIT_HALT_IDLE] && !apb_wr) |=> $stable(st_q.cnt_lo))
        else $error("low timer counted while halted in idle");

    a_lo_wrap_flag: assert property (
        s_lo_wrap_cause |=> s_lo_wrapped)
        else $error("low timer did not wrap and flag at period");

    a_lo_step_one: assert property (
        (tick_lo && !join_wide_mode && !lo_wrap && !apb_wr)
        |=> st_q.cnt_lo == $past(st_q.cnt_lo) + 16'h0001)
        else $error("low timer did not step by one");

    a_gate_low_holds: assert property (
        (!join_wide_mode && lo_gated && !ext_lo && !st_q.ext_lo_prev && !apb_wr)
        ##1 (!ext_lo && !apb_wr) |=> $stable(st_q.cnt_lo))
        else $error("gated low timer counted with gate low");

    a_joined_carry: assert property (
        s_carry_cause |=> st_q.cnt_hi == $past(st_q.cnt_hi) + 16'h0001
                          && st_q.cnt_lo == 16'h0000)
        else $error("joined counter carry into high word lost");

    a_joined_no_lo_irq: assert property (
        $rose(st_q.stat[IRQ_LO]) |-> !$past(join_wide_mode))
        else $error("joined counter raised the low-word event");

    a_hi_ignored_joined: assert property (
        (join_wide_mode && !lo_on && !apb_wr) [*2] |-> !tick_hi)
        else $error("high controls counted in joined mode");

    a_ctrl_read_zero: assert property (
        (pready && psel && !pwrite && paddr == OFF_CTRL_LO)
        |-> (prdata[15:0] & ~MASK_CTRL_LO) == 16'h0000 && prdata[31:16] == 16'h0000)
        else $error("unimplemented control bits read nonzero");

    a_irq_follows: assert property (
        ##1 irq == |(st_q.stat & st_q.mask))
        else $error("interrupt output disagrees with masked status");

endmodule // cdt_timer_pair

// file: bench/cdt_pin_src.sv
module cdt_pin_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [7:0] n_pulses,
    input  wire logic       level,
    output logic            pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] ph;
    logic [7:0] left;

    // external count clock
    // two high and two low per pulse, so the two-flop sync never drops an edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin  <= 1'b0;
            busy <= 1'b0;
            ph   <= 2'h0;
            left <= 8'h00;
        end else if (busy) begin
            pin <= (ph < 2'h2);
            ph  <= ph + 2'h1;
            if (ph == 2'h3) begin
                left <= left - 8'h01;
                busy <= (left != 8'h01);
            end
        end else if (go && n_pulses != 8'h00) begin
            busy <= 1'b1;
            left <= n_pulses;
            ph   <= 2'h0;
            pin  <= level;
        end else begin
            pin <= level;
        end
    end
endmodule // cdt_pin_src

// file: bench/tb.sv
module tb;
    import cdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
        logic        err;
        logic        chk;
    } cdt_note_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        cpu_idle = 1'b0;
    logic [4:0]  paddr = 5'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pin_lo, pin_hi, busy_lo, busy_hi;
    logic        go = 1'b0;
    logic        lvl_lo = 1'b0;
    logic [7:0]  np_lo = 8'h00;
    logic [7:0]  np_hi = 8'h00;
    logic [15:0] rv;
    int          err_total = 0;
    int          total_checks = 0;
    int          ratio;
    cdt_note_t   notes[$];
    cdt_note_t   nt;

    always #12.5 pclk = ~pclk;

    cdt_timer_pair cdt_timer_pair_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input_lo(pin_lo), .external_count_input_hi(pin_hi),
        .cpu_idle(cpu_idle), .irq(irq));
    cdt_pin_src src_lo (.pclk(pclk), .presetn(presetn), .go(go), .n_pulses(np_lo),
        .level(lvl_lo), .pin(pin_lo), .busy(busy_lo));
    cdt_pin_src src_hi (.pclk(pclk), .presetn(presetn), .go(go), .n_pulses(np_hi),
        .level(1'b0), .pin(pin_hi), .busy(busy_hi));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [31:0] v, lo, hi);
        total_checks++;
        if (((v >= lo) && (v <= hi)) !== 1'b1) begin
            err_total++;
            $display("unexpected %s expected %0h..%0h seen %0h", nm, lo, hi, v);
        end
    endtask

    task automatic chk_bit(input string nm, input logic v, e);
        total_checks++;
        if (v !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", nm, e, v);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; the answer is judged by the watcher below
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, lo, hi,
                        input logic err);
        int n;
        notes.push_back('{lo, hi, err, !wr});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            tally_and_finish();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        xfer(1'b1, a, {16'h0, d}, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] lo, hi);
        xfer(1'b0, a, 32'h0, lo, hi, 1'b0);
    endtask

    task automatic pulse(input logic [7:0] nl, nh);
        int n;
        @(posedge pclk);
        np_lo <= nl;
        np_hi <= nh;
        go    <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((busy_lo | busy_hi) !== 1'b0 && n < 3000);
        if (n >= 3000) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                err_total++;
                $display("unexpected pready expected 0 seen 1");
            end else begin
                nt = notes.pop_front();
                chk_bit("pslverr", pslverr, nt.err);
                if (nt.chk)
                    chk_val("prdata", prdata, nt.lo, nt.hi);
            end
        end
    end

    initial begin
        void'($urandom(34));
        cyc(16);
        presetn <= 1'b1;
        cyc(1);
        // offsets run 00..1C in steps of four; only the periods reset to all ones
        for (int i = 0; i < 8; i++) begin
            rd(5'(i * 4), (i == 4 || i == 5) ? 32'hFFFF : 32'h0,
               (i == 4 || i == 5) ? 32'hFFFF : 32'h0);
        end
        chk_bit("irq", irq, 1'b0);
        xfer(1'b0, 5'h03, 32'h0, 32'h0, 32'h0, 1'b1);
        wr(OFF_CTRL_LO, 16'hFFFF);
        rd(OFF_CTRL_LO, 32'hA07A, 32'hA07A);
        wr(OFF_CTRL_HI, 16'hFFFF);
        rd(OFF_CTRL_HI, 32'hA072, 32'hA072);
        wr(OFF_CTRL_HI, 16'h0000);
        wr(OFF_CTRL_LO, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ratio = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : 256;
            wr(OFF_COUNT_LO, 16'h0000);
            wr(OFF_CTRL_LO, 16'h8000 | 16'(i << 4));
            // two cycles of tick latency: four prescaled ticks land inside this window
            cyc(4 * ratio - 2);
            wr(OFF_CTRL_LO, 16'h0000);
            rd(OFF_COUNT_LO, 32'd3, 32'd5);
        end
        rv = 16'($urandom_range(999));
        wr(OFF_COUNT_LO, rv);
        wr(OFF_COUNT_HI, 16'h0000);
        wr(OFF_CTRL_LO, 16'h8042);
        wr(OFF_CTRL_HI, 16'h8002);
        pulse(8'd5, 8'd3);
        cyc(6);
        rd(OFF_COUNT_LO, {16'h0, rv + 16'd5}, {16'h0, rv + 16'd5});
        rd(OFF_COUNT_HI, 32'd3, 32'd3);
        wr(OFF_CTRL_HI, 16'h0000);
        wr(OFF_COUNT_LO, 16'h0000);
        wr(OFF_IRQ_STAT, 16'h0003);
        wr(OFF_CTRL_LO, 16'h8040);
        cyc(10);
        rd(OFF_COUNT_LO, 32'd0, 32'd0);
        lvl_lo <= 1'b1;
        cyc(20);
        lvl_lo <= 1'b0;
        cyc(6);
        rd(OFF_COUNT_LO, 32'd17, 32'd23);
        rd(OFF_IRQ_STAT, 32'd1, 32'd1);
        wr(OFF_PERIOD_LO, 16'h0002);
        wr(OFF_COUNT_LO, 16'h0000);
        wr(OFF_IRQ_STAT, 16'h0003);
        wr(OFF_CTRL_LO, 16'h8000);
        cyc(10);
        wr(OFF_CTRL_LO, 16'h0000);
        rd(OFF_COUNT_LO, 32'd0, 32'd2);
        rd(OFF_IRQ_STAT, 32'd1, 32'd1);
        wr(OFF_PERIOD_LO, 16'hFFFF);
        cpu_idle <= 1'b1;
        wr(OFF_COUNT_LO, 16'h0000);
        wr(OFF_COUNT_HI, 16'h0000);
        wr(OFF_CTRL_LO, 16'hA000);
        wr(OFF_CTRL_HI, 16'h8000);
        cyc(20);
        rd(OFF_COUNT_LO, 32'd0, 32'd0);
        rd(OFF_COUNT_HI, 32'd20, 32'd45);
        cpu_idle <= 1'b0;
        wr(OFF_CTRL_HI, 16'h0000);
        wr(OFF_CTRL_LO, 16'h0000);
        wr(OFF_IRQ_STAT, 16'h0003);
        wr(OFF_PERIOD_HI, 16'h0001);
        wr(OFF_COUNT_LO, 16'hFFFC);
        // the idle run left the high word holding a nonzero count
        wr(OFF_COUNT_HI, 16'h0000);
        // high controls off, gated, 1:256, external: all must be ignored when joined
        wr(OFF_CTRL_HI, 16'h0072);
        wr(OFF_CTRL_LO, 16'h8008);
        cyc(4);
        wr(OFF_CTRL_LO, 16'h0008);
        rd(OFF_COUNT_HI, 32'd1, 32'd1);
        rd(OFF_COUNT_LO, 32'd1, 32'd10);
        cpu_idle <= 1'b1;
        wr(OFF_COUNT_HI, 16'h0001);
        wr(OFF_COUNT_LO, 16'hFFF0);
        wr(OFF_CTRL_LO, 16'h8008);
        cyc(40);
        wr(OFF_CTRL_LO, 16'h0008);
        cpu_idle <= 1'b0;
        rd(OFF_COUNT_HI, 32'd0, 32'd0);
        rd(OFF_COUNT_LO, 32'd15, 32'd40);
        rd(OFF_IRQ_STAT, 32'd2, 32'd2);
        chk_bit("irq", irq, 1'b0);
        wr(OFF_IRQ_MASK, 16'h0002);
        cyc(2);
        chk_bit("irq", irq, 1'b1);
        wr(OFF_IRQ_MASK, 16'h0001);
        cyc(2);
        chk_bit("irq", irq, 1'b0);
        wr(OFF_IRQ_MASK, 16'h0003);
        wr(OFF_IRQ_STAT, 16'h0002);
        cyc(2);
        chk_bit("irq", irq, 1'b0);
        rd(OFF_IRQ_MASK, 32'd3, 32'd3);
        // high word on its own at 1:8, period back to all ones
        wr(OFF_CTRL_LO, 16'h0000);
        wr(OFF_PERIOD_HI, 16'hFFFF);
        wr(OFF_COUNT_HI, 16'h0000);
        wr(OFF_CTRL_HI, 16'h8010);
        cyc(30);
        wr(OFF_CTRL_HI, 16'h0000);
        rd(OFF_COUNT_HI, 32'd3, 32'd5);
        cyc(4);
        tally_and_finish();
    end
endmodule // tb
